// ### core/tc_ctrl_pkg.sv
// Package of shared constants for the thermocouple measurement control block.
// Assumes every user writes package::name and imports nothing.
package tc_ctrl_pkg;

    // Register pointers of the two configuration registers.
    localparam logic [7:0] PTR_SENSOR_CFG = 8'h05;
    localparam logic [7:0] PTR_DEVICE_CFG = 8'h06;

    // Power-on values of both configuration registers.
    localparam logic [7:0] SENSOR_CFG_RESET = 8'h00;
    localparam logic [7:0] DEVICE_CFG_RESET = 8'h00;

    // Sensor configuration fields.
    localparam int TYPE_LSB = 4;
    localparam int TYPE_MSB = 6;
    localparam int COEF_LSB = 0;
    localparam int COEF_MSB = 2;
    localparam logic [7:0] SENSOR_CFG_WMASK = 8'h77;

    // Device configuration fields.
    localparam int CJ_RES_BIT = 7;
    localparam int ADC_RES_LSB = 5;
    localparam int ADC_RES_MSB = 6;
    localparam int BURST_LSB = 2;
    localparam int BURST_MSB = 4;
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 1;

    // Power mode codes.
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SHUTDOWN = 2'h1;
    localparam logic [1:0] MODE_BURST = 2'h2;
    localparam logic [1:0] MODE_IGNORED = 2'h3;

    // Temperature words and alert limits.
    localparam int TEMP_W = 16;
    localparam int ALERT_N = 4;
    localparam logic [15:0] LIMIT_MASK = 16'hfffc;

    // Filter divider.
    localparam int DIV_STEPS = 18;
    localparam logic [4:0] DIV_LAST = 5'h11;

endpackage

// ### core/ema_filter.sv
// Recursive exponential average filter for hot-junction samples.
// Assumes in_valid only while idle; clear may arrive at any time.
`timescale 1ns/100ps
module ema_filter (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Control.
    input wire logic clear,
    input wire logic [2:0] coef,
    // Raw sample in.
    input wire logic in_valid,
    input wire logic [15:0] in_sample,
    // Filtered sample out.
    output logic out_valid,
    output logic [15:0] out_sample
);
    logic primed_q, primed_d;
    logic busy_q, busy_d;
    logic neg_q, neg_d;
    logic [4:0] step_q, step_d;
    logic [17:0] num_q, num_d;
    logic [9:0] rem_q, rem_d;
    logic [8:0] div_q, div_d;
    logic [15:0] y_q, y_d;
    logic valid_q, valid_d;
    logic [16:0] diff;
    logic [16:0] mag;
    logic [9:0] rem_sh;
    logic [17:0] y_ext;

    // The divide by 2^n+1 is done bit-serially; a sample takes 18 cycles,
    // which is far shorter than any conversion, so area wins over speed.
    always_comb begin
        primed_d = primed_q;
        busy_d = busy_q;
        neg_d = neg_q;
        step_d = step_q;
        num_d = num_q;
        rem_d = rem_q;
        div_d = div_q;
        y_d = y_q;
        valid_d = 1'b0;
        diff = {in_sample[15], in_sample} - {y_q[15], y_q};
        mag = diff[16] ? 17'(-diff) : diff;
        rem_sh = {rem_q[8:0], num_q[17]};
        y_ext = {{2{y_q[15]}}, y_q};
        if (clear) begin
            primed_d = 1'b0;
            busy_d = 1'b0;
        end else if (in_valid && !busy_q) begin
            if (coef == 3'h0 || !primed_q) begin
                y_d = in_sample;
                primed_d = 1'b1;
                valid_d = 1'b1;
            end else begin
                // Y + 2(X-Y)/(2^n+1) equals kX + (1-k)Y.
                busy_d = 1'b1;
                neg_d = diff[16];
                num_d = {mag, 1'b0};
                rem_d = 10'h000;
                step_d = 5'h00;
                div_d = 9'((9'h001 << coef) + 9'h001);
            end
        end else if (busy_q) begin
            num_d = {num_q[16:0], 1'b0};
            if (rem_sh >= {1'b0, div_q}) begin
                rem_d = rem_sh - {1'b0, div_q};
                num_d[0] = 1'b1;
            end else begin
                rem_d = rem_sh;
            end
            step_d = 5'(step_q + 5'h01);
            if (step_q == tc_ctrl_pkg::DIV_LAST) begin
                busy_d = 1'b0;
                valid_d = 1'b1;
                y_d = neg_q ? 16'(y_ext - num_d) : 16'(y_ext + num_d);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            primed_q <= 1'b0;
            busy_q <= 1'b0;
            neg_q <= 1'b0;
            step_q <= 5'h00;
            num_q <= 18'h0_0000;
            rem_q <= 10'h000;
            div_q <= 9'h001;
            y_q <= 16'h0000;
            valid_q <= 1'b0;
        end else begin
            primed_q <= primed_d;
            busy_q <= busy_d;
            neg_q <= neg_d;
            step_q <= step_d;
            num_q <= num_d;
            rem_q <= rem_d;
            div_q <= div_d;
            y_q <= y_d;
            valid_q <= valid_d;
        end
    end

    assign out_valid = valid_q;
    assign out_sample = y_q;
endmodule // ema_filter

// ### core/alert_compare.sv
// One alert status flag: compares a monitored temperature with its limit.
// Assumes the limit is a two's complement word whose two low bits do not exist.
`timescale 1ns/100ps
module alert_compare (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Sample strobe and temperatures.
    input wire logic sample_valid,
    input wire logic [15:0] hot_temp,
    input wire logic [15:0] cold_temp,
    // Settings.
    input wire logic monitor_cold,
    input wire logic [15:0] limit,
    // Status.
    output logic status
);
    logic status_q, status_d;
    logic signed [15:0] t_x;
    logic signed [15:0] lim;

    always_comb begin
        t_x = monitor_cold ? cold_temp : hot_temp;
        lim = limit & tc_ctrl_pkg::LIMIT_MASK;
        status_d = status_q;
        if (sample_valid) begin
            status_d = (t_x > lim);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            status_q <= 1'b0;
        end else begin
            status_q <= status_d;
        end
    end

    assign status = status_q;
endmodule // alert_compare

// ### core/tc_measure_ctrl.sv
// Measurement control of a thermocouple converter: configuration registers,
// power modes, burst sequencing, hot-junction filtering and alert status.
// Assumes a serial bus engine drives the register port and a converter
// answers each conv_start with one conv_done pulse carrying a raw sample.
//
// How it works
// - Sensor config bits 6-4 pick thermocouple type K,J,T,N,S,E,B,R.
// - Sensor config bits 2-0 set filter coefficient n; zero bypasses filtering.
// - Filtered output is k*X + (1-k)*Yprev with k = 2/(2^n+1).
// - Any write to sensor config discards the previous filtered value.
// - Raw hot-junction sample feeds the filter; its output is the reported value.
// - Device config bit 7 picks cold-junction step, 0.0625 or 0.25 degrees.
// - Device config bits 6-5 pick 18, 16, 14 or 12 bit conversion.
// - Resolution changes take effect only when the next measurement starts.
// - Bits 1-0: normal, shutdown, burst; code 11 changes nothing.
// - Shutdown stops conversions and power-consuming activity until mode changes.
// - All registers stay readable and writable during shutdown.
// - Burst takes 2^code samples from bits 4-2, then enters shutdown.
// - Each burst sample is compared with the alert limits.
// - With filtering on, burst alerts compare the filtered value.
// - Sensor config bits 7 and 3 read zero and ignore writes.
// - Alert flag is one when the monitored temperature exceeds its limit.
`timescale 1ns/100ps
module tc_measure_ctrl (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Register port from the serial bus engine.
    input wire logic reg_wr,
    input wire logic [7:0] reg_ptr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Converter control and results.
    output logic adc_power_en,
    output logic conv_start,
    output logic [1:0] conv_res,
    output logic cj_res,
    output logic [2:0] tc_type,
    input wire logic conv_done,
    input wire logic [15:0] conv_hot_raw,
    input wire logic [15:0] cold_temp,
    // Alert limits and monitor selection, alert n in bits 16n+15..16n.
    input wire logic [63:0] alert_limits,
    input wire logic [3:0] alert_monitor_cold,
    output logic [3:0] alert_status,
    // Reported hot-junction temperature.
    output logic [15:0] hot_temp,
    output logic hot_valid,
    output logic burst_active
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_CONVERT,
        ST_FILTER,
        ST_NEXT
    } state_t;

    state_t state_q, state_d;
    logic [7:0] sensor_cfg_q, sensor_cfg_d;
    logic [7:0] dev_cfg_q, dev_cfg_d;
    logic [1:0] mode_q, mode_d;
    logic [7:0] burst_left_q, burst_left_d;
    logic burst_q, burst_d;
    logic [1:0] conv_res_q, conv_res_d;
    logic cj_res_q, cj_res_d;
    logic [2:0] tc_type_q, tc_type_d;
    logic start_q, start_d;
    logic [15:0] hot_q, hot_d;
    logic hot_valid_q, hot_valid_d;
    logic [7:0] rdata_q, rdata_d;
    logic wr_sensor;
    logic wr_device;
    logic [1:0] wr_mode;
    logic filt_valid;
    logic [15:0] filt_sample;

    assign wr_sensor = reg_wr && (reg_ptr == tc_ctrl_pkg::PTR_SENSOR_CFG);
    assign wr_device = reg_wr && (reg_ptr == tc_ctrl_pkg::PTR_DEVICE_CFG);
    assign wr_mode = reg_wdata[tc_ctrl_pkg::MODE_MSB:tc_ctrl_pkg::MODE_LSB];

    // Register file. The port is served in every state, shutdown included.
    always_comb begin
        sensor_cfg_d = sensor_cfg_q;
        dev_cfg_d = dev_cfg_q;
        mode_d = mode_q;
        rdata_d = 8'h00;
        if (wr_sensor) begin
            sensor_cfg_d = reg_wdata & tc_ctrl_pkg::SENSOR_CFG_WMASK;
        end
        if (wr_device) begin
            dev_cfg_d = reg_wdata;
            if (wr_mode != tc_ctrl_pkg::MODE_IGNORED) begin
                mode_d = wr_mode;
            end
        end else if (burst_q && state_q == ST_NEXT && burst_left_q == 8'h01) begin
            // The last burst sample drops the device into shutdown, and the
            // mode field shows it so software can poll for the end.
            mode_d = tc_ctrl_pkg::MODE_SHUTDOWN;
            dev_cfg_d[tc_ctrl_pkg::MODE_MSB:tc_ctrl_pkg::MODE_LSB] =
                tc_ctrl_pkg::MODE_SHUTDOWN;
        end
        unique case (reg_ptr)
            tc_ctrl_pkg::PTR_SENSOR_CFG: rdata_d = sensor_cfg_q;
            tc_ctrl_pkg::PTR_DEVICE_CFG: rdata_d = dev_cfg_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sensor_cfg_q <= tc_ctrl_pkg::SENSOR_CFG_RESET;
            dev_cfg_q <= tc_ctrl_pkg::DEVICE_CFG_RESET;
            mode_q <= tc_ctrl_pkg::MODE_NORMAL;
            rdata_q <= 8'h00;
        end else begin
            sensor_cfg_q <= sensor_cfg_d;
            dev_cfg_q <= dev_cfg_d;
            mode_q <= mode_d;
            rdata_q <= rdata_d;
        end
    end

    // Measurement sequencer. A mode change lets a conversion in flight finish
    // rather than leave the converter in an undefined half-done state.
    always_comb begin
        state_d = state_q;
        burst_left_d = burst_left_q;
        burst_d = burst_q;
        conv_res_d = conv_res_q;
        cj_res_d = cj_res_q;
        tc_type_d = tc_type_q;
        start_d = 1'b0;
        hot_d = hot_q;
        hot_valid_d = 1'b0;
        if (wr_device && wr_mode == tc_ctrl_pkg::MODE_BURST) begin
            burst_d = 1'b1;
            burst_left_d = 8'(8'h01 <<
                reg_wdata[tc_ctrl_pkg::BURST_MSB:tc_ctrl_pkg::BURST_LSB]);
        end else if (wr_device && wr_mode != tc_ctrl_pkg::MODE_IGNORED) begin
            burst_d = 1'b0;
        end
        unique case (state_q)
            ST_IDLE: begin
                // The mode being written this cycle decides, so a shutdown
                // written while idle never lets one more conversion slip out.
                if (mode_d == tc_ctrl_pkg::MODE_NORMAL ||
                    (mode_d == tc_ctrl_pkg::MODE_BURST && burst_d)) begin
                    state_d = ST_START;
                end
            end
            ST_START: begin
                // Resolution and type are sampled only here.
                conv_res_d = dev_cfg_q[tc_ctrl_pkg::ADC_RES_MSB:tc_ctrl_pkg::ADC_RES_LSB];
                cj_res_d = dev_cfg_q[tc_ctrl_pkg::CJ_RES_BIT];
                tc_type_d = sensor_cfg_q[tc_ctrl_pkg::TYPE_MSB:tc_ctrl_pkg::TYPE_LSB];
                start_d = 1'b1;
                state_d = ST_CONVERT;
            end
            ST_CONVERT: begin
                if (conv_done) begin
                    state_d = ST_FILTER;
                end
            end
            ST_FILTER: begin
                if (wr_sensor) begin
                    // The filter dropped this sample with its history.
                    state_d = ST_NEXT;
                end else if (filt_valid) begin
                    hot_d = filt_sample;
                    hot_valid_d = 1'b1;
                    state_d = ST_NEXT;
                end
            end
            ST_NEXT: begin
                if (burst_q && !(wr_device && wr_mode == tc_ctrl_pkg::MODE_BURST)) begin
                    burst_left_d = 8'(burst_left_q - 8'h01);
                    if (burst_left_q == 8'h01) begin
                        burst_d = 1'b0;
                    end
                end
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            burst_left_q <= 8'h00;
            burst_q <= 1'b0;
            conv_res_q <= 2'h0;
            cj_res_q <= 1'b0;
            tc_type_q <= 3'h0;
            start_q <= 1'b0;
            hot_q <= 16'h0000;
            hot_valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            burst_left_q <= burst_left_d;
            burst_q <= burst_d;
            conv_res_q <= conv_res_d;
            cj_res_q <= cj_res_d;
            tc_type_q <= tc_type_d;
            start_q <= start_d;
            hot_q <= hot_d;
            hot_valid_q <= hot_valid_d;
        end
    end

    ema_filter u_filter (
        .sys_clk(sys_clk),
        .reset(reset),
        .clear(wr_sensor),
        .coef(sensor_cfg_q[tc_ctrl_pkg::COEF_MSB:tc_ctrl_pkg::COEF_LSB]),
        .in_valid(state_q == ST_CONVERT && conv_done),
        .in_sample(conv_hot_raw),
        .out_valid(filt_valid),
        .out_sample(filt_sample)
    );

    // Alerts are judged at each sample on the reported, filtered value, or on cold_temp where alert_monitor_cold is set.
    for (genvar i = 0; i < tc_ctrl_pkg::ALERT_N; i++) begin : g_alert
        alert_compare u_alert (
            .sys_clk(sys_clk),
            .reset(reset),
            .sample_valid(hot_valid_q),
            .hot_temp(hot_q),
            .cold_temp(cold_temp),
            .monitor_cold(alert_monitor_cold[i]),
            .limit(alert_limits[16*i +: 16]),
            .status(alert_status[i])
        );
    end

    // The converter is powered only while a measurement is under way.
    assign adc_power_en = (state_q != ST_IDLE);
    assign conv_start = start_q;
    assign conv_res = conv_res_q;
    assign cj_res = cj_res_q;
    assign tc_type = tc_type_q;
    assign hot_temp = hot_q;
    assign hot_valid = hot_valid_q;
    assign burst_active = burst_q;
    assign reg_rdata = rdata_q;
endmodule // tc_measure_ctrl

// ### sim/tc_ctrl_checker_asserts.sv
// Port-level checker for the thermocouple measurement control block.
// Assumes it is bound to tc_measure_ctrl and sees only that module's ports.
`timescale 1ns/100ps
module tc_ctrl_checker (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Register port.
    input wire logic reg_wr,
    input wire logic [7:0] reg_ptr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Converter link and results.
    input wire logic adc_power_en,
    input wire logic conv_start,
    input wire logic [1:0] conv_res,
    input wire logic cj_res,
    input wire logic [2:0] tc_type,
    input wire logic conv_done,
    input wire logic [3:0] alert_status,
    input wire logic hot_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    start_power_a: assert property (conv_start |-> adc_power_en ##1 adc_power_en)
        else $error("conversion started without converter power");
    hot_latency_a: assert property (hot_valid |-> $past(conv_done, 2) || $past(conv_done, 20))
        else $error("reported sample without matching conversion");
    // Settings may only move at a measurement start, never inside a conversion.
    res_hold_a: assert property (!$past(reset) && ($changed(conv_res) || $changed(cj_res)
        || $changed(tc_type)) |-> ((conv_start || $past(conv_start)) or (##1 conv_start)))
        else $error("measurement settings changed mid conversion");
    shutdown_quiet_a: assert property (reg_wr && reg_ptr == tc_ctrl_pkg::PTR_DEVICE_CFG
        && reg_wdata[1:0] == tc_ctrl_pkg::MODE_SHUTDOWN |=> ##1 !conv_start [*8])
        else $error("conversion started in shutdown");
    alert_cause_a: assert property (!$past(reset) && !$stable(alert_status) |-> $past(hot_valid))
        else $error("alert status moved without a sample");
    reserved_zero_a: assert property ($past(reg_ptr) == tc_ctrl_pkg::PTR_SENSOR_CFG
        |-> (reg_rdata & ~tc_ctrl_pkg::SENSOR_CFG_WMASK) == 8'h00)
        else $error("unimplemented sensor bits read nonzero");
    dev_readback_a: assert property (reg_wr && reg_ptr == tc_ctrl_pkg::PTR_DEVICE_CFG ##1
        reg_ptr == tc_ctrl_pkg::PTR_DEVICE_CFG && !reg_wr |=> reg_rdata == $past(reg_wdata, 2))
        else $error("device configuration readback differs");
endmodule // tc_ctrl_checker

bind tc_measure_ctrl tc_ctrl_checker u_checker (
    .sys_clk(sys_clk), .reset(reset), .reg_wr(reg_wr), .reg_ptr(reg_ptr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_power_en(adc_power_en),
    .conv_start(conv_start), .conv_res(conv_res), .cj_res(cj_res), .tc_type(tc_type),
    .conv_done(conv_done), .alert_status(alert_status), .hot_valid(hot_valid)
);

// ### sim/conv_model.sv
// Behavioural converter: answers each start with one done pulse and a sample.
// Assumes the bench supplies the latency and the next raw sample.
`timescale 1ns/100ps
module conv_model (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Requests from the control block.
    input wire logic adc_power_en,
    input wire logic conv_start,
    // Stimulus from the bench.
    input wire logic [7:0] lat,
    input wire logic [15:0] next_raw,
    // Results.
    output logic conv_done = 1'b0,
    output logic [15:0] conv_hot_raw = 16'h0000
);
    logic busy_q;
    logic [7:0] cnt_q;

    // Outside its pulse the sample toggles, so stale data never looks valid.
    // Losing power aborts a conversion, as an unpowered converter would.
    always @(posedge sys_clk) begin
        conv_done <= 1'b0;
        conv_hot_raw <= ~conv_hot_raw;
        if (reset || !adc_power_en) begin
            busy_q <= 1'b0;
        end else if (conv_start) begin
            busy_q <= 1'b1;
            cnt_q <= lat;
        end else if (busy_q && cnt_q == 8'h00) begin
            conv_done <= 1'b1;
            conv_hot_raw <= next_raw;
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule // conv_model

// ### sim/test_tc_measure_ctrl.sv
// Self-checking bench for the thermocouple measurement control block.
// Assumes conv_model stands in for the converter and the checker binds itself.
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module test_tc_measure_ctrl;
    typedef struct {logic [15:0] temp; logic [3:0] alert;} note_t;
    logic sys_clk, reset, reg_wr, conv_done, adc_power_en, conv_start, cj_res;
    logic hot_valid, burst_active;
    logic [7:0] reg_ptr, reg_wdata, reg_rdata, lat;
    logic [1:0] conv_res;
    logic [2:0] tc_type, n_cur;
    logic [15:0] conv_hot_raw, cold_temp, hot_temp, next_raw, y_prev, y_new;
    logic [63:0] alert_limits;
    logic [3:0] alert_monitor_cold, alert_status, a_new;
    bit y_ok;
    int fails, cmp_count, hv_count, sc_count, snap;
    note_t note_q[$];
    note_t got;

    tc_measure_ctrl DUT (.sys_clk(sys_clk), .reset(reset), .reg_wr(reg_wr),
        .reg_ptr(reg_ptr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .adc_power_en(adc_power_en), .conv_start(conv_start), .conv_res(conv_res),
        .cj_res(cj_res), .tc_type(tc_type), .conv_done(conv_done),
        .conv_hot_raw(conv_hot_raw), .cold_temp(cold_temp), .alert_limits(alert_limits),
        .alert_monitor_cold(alert_monitor_cold), .alert_status(alert_status),
        .hot_temp(hot_temp), .hot_valid(hot_valid), .burst_active(burst_active));
    conv_model u_conv (.sys_clk(sys_clk), .reset(reset), .adc_power_en(adc_power_en),
        .conv_start(conv_start), .lat(lat), .next_raw(next_raw), .conv_done(conv_done),
        .conv_hot_raw(conv_hot_raw));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Result is truncated toward the previous output; n of zero passes the sample.
    function automatic logic [15:0] filt(input logic [15:0] x, y, input logic [2:0] n);
        int d;
        int q;
        d = $signed(x) - $signed(y);
        q = (2 * (d < 0 ? -d : d)) / ((1 << n) + 1);
        return (d < 0) ? y - 16'(q) : y + 16'(q);
    endfunction

    task tick();
        @(posedge sys_clk);
        #1;
    endtask

    task wr(input logic [7:0] p, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_ptr = p;
        reg_wdata = d;
        if (p == tc_ctrl_pkg::PTR_SENSOR_CFG) begin
            y_ok = 1'b0;
            n_cur = d[2:0];
        end
        tick();
        reg_wr = 1'b0;
    endtask

    task rd(input logic [7:0] p, input logic [7:0] e);
        reg_ptr = p;
        tick();
        tick();
        `CHK(reg_rdata, e)
    endtask

    // Shutdown, then leave room for an in-flight conversion to finish.
    task sd();
        wr(tc_ctrl_pkg::PTR_DEVICE_CFG, 8'h01);
        repeat (40) tick();
    endtask

    task wait_start();
        for (int i = 0; i < 200 && conv_start !== 1'b1; i++) tick();
        `CHK(conv_start, 1'b1)
    endtask

    task run(input int k);
        int s;
        s = hv_count;
        for (int i = 0; i < 3000 && hv_count < s + k; i++) tick();
        `CHK(hv_count >= s + k, 1'b1)
    endtask

    task wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Driver side: note the expected report for every sample the converter hands over.
    always @(posedge sys_clk) begin
        if (conv_start === 1'b1) sc_count++;
        if (conv_done === 1'b1) begin
            y_new = y_ok ? filt(conv_hot_raw, y_prev, n_cur) : conv_hot_raw;
            for (int i = 0; i < 4; i++) a_new[i] = $signed(alert_monitor_cold[i] ?
                cold_temp : y_new) > $signed(alert_limits[16*i +: 16] & tc_ctrl_pkg::LIMIT_MASK);
            note_q.push_back('{y_new, a_new});
            y_prev = y_new;
            y_ok = 1'b1;
            lat <= 8'($urandom % 9);
            next_raw <= 16'($urandom % 4096);
        end
    end

    initial forever begin
        tick();
        if (hot_valid === 1'b1) begin
            hv_count++;
            `CHK(note_q.size() != 0, 1'b1)
            if (note_q.size() != 0) begin
                got = note_q.pop_front();
                `CHK(hot_temp, got.temp)
                tick();
                `CHK(alert_status, got.alert)
            end
        end
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        fails++;
        wrap_up();
    end

    initial begin
        void'($urandom(16663));
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_ptr = 8'h00;
        reg_wdata = 8'h00;
        lat = 8'h03;
        next_raw = 16'h0123;
        cold_temp = 16'h0100;
        alert_limits = 64'h0000_0000_0000_0000;
        alert_monitor_cold = 4'h0;
        n_cur = 3'h0;
        repeat (20) tick();
        reset = 1'b0;
        rd(tc_ctrl_pkg::PTR_SENSOR_CFG, 8'h00);
        rd(tc_ctrl_pkg::PTR_DEVICE_CFG, 8'h00);
        run(3);
        wait_start();
        wr(tc_ctrl_pkg::PTR_DEVICE_CFG, 8'h40);
        `CHK(conv_res, 2'h0)
        wait_start();
        tick();
        `CHK(conv_res, 2'h2)
        sd();
        snap = sc_count;
        repeat (60) tick();
        `CHK(sc_count, snap)
        `CHK(adc_power_en, 1'b0)
        wr(tc_ctrl_pkg::PTR_DEVICE_CFG, 8'h43);
        repeat (60) tick();
        `CHK(sc_count, snap)
        rd(tc_ctrl_pkg::PTR_DEVICE_CFG, 8'h43);
        wr(tc_ctrl_pkg::PTR_SENSOR_CFG, 8'hff);
        rd(tc_ctrl_pkg::PTR_SENSOR_CFG, 8'h77);
        wr(8'h07, 8'h5a);
        rd(8'h07, 8'h00);
        for (int t = 0; t < 8; t++) begin
            sd();
            wr(tc_ctrl_pkg::PTR_SENSOR_CFG, {1'b0, 3'(t), 4'h0});
            wr(tc_ctrl_pkg::PTR_DEVICE_CFG, {t[0], t[2:1], 5'h00});
            wait_start();
            tick();
            `CHK(tc_type, 3'(t))
            `CHK(conv_res, t[2:1])
            `CHK(cj_res, t[0])
        end
        for (int n = 0; n < 8; n++) begin
            sd();
            for (int i = 0; i < 4; i++) alert_limits[16*i +: 16] = 16'($urandom % 4096);
            alert_monitor_cold = 4'($urandom);
            cold_temp = 16'($urandom % 4096);
            wr(tc_ctrl_pkg::PTR_SENSOR_CFG, {1'b0, 3'($urandom % 8), 1'b0, 3'(n)});
            wr(tc_ctrl_pkg::PTR_DEVICE_CFG, 8'h00);
            run(4);
        end
        for (int c = 0; c < 8; c++) begin
            sd();
            wr(tc_ctrl_pkg::PTR_SENSOR_CFG, {5'h00, 3'(7 - c)});
            snap = hv_count;
            wr(tc_ctrl_pkg::PTR_DEVICE_CFG, {3'h0, 3'(c), 2'h2});
            tick();
            tick();
            for (int i = 0; i < 8000 && (burst_active === 1'b1 || adc_power_en !== 1'b0); i++)
                tick();
            repeat (4) tick();
            `CHK(hv_count - snap, 1 << c)
            rd(tc_ctrl_pkg::PTR_DEVICE_CFG, {3'h0, 3'(c), 2'h1});
        end
        wrap_up();
    end
endmodule // test_tc_measure_ctrl
